/* hdl/alu_status_word_flags_pkg.sv */
// How it works
// RULE1: Zero result sets zero flag, bit 7.
// RULE2: Carry-chain ops only clear zero, never set.
// RULE3: Negative flag, bit 6, shows true sign.
// RULE4: Shifts and normalize load negative from msb.
// RULE5: Unrepresentable result sets overflow flag, bit 5.
// RULE6: Left shift overflow when msb ever changes.
// RULE7: Overflow sets trap bit 4; three instructions clear.
// RULE8: Carry bit 3: carry out or last bit out.
// RULE9: Subtract borrow clears carry flag.
// RULE10: Right shift residue bit 0 on carry reuse.
// RULE11: Bit 2 enables transaction server; two instructions.
// RULE12: Bit 1 gates maskable interrupts; two instructions.
// RULE13: Push saves word then clears; pop restores.
// RULE14: No register address path to status byte.
// RULE15: Word: flags high byte, mask low byte.
// RULE16: Unaffected flags hold; reset clears all.
package alu_status_word_flags_pkg;

  // ==========================================================
  // Status byte layout
  localparam int FLAG_ZERO      = 7;
  localparam int FLAG_NEGATIVE  = 6;
  localparam int FLAG_OVERFLOW  = 5;
  localparam int FLAG_TRAP      = 4;
  localparam int FLAG_CARRY     = 3;
  localparam int FLAG_TS_ENABLE = 2;
  localparam int FLAG_INT_EN    = 1;
  localparam int FLAG_RESIDUE   = 0;
  localparam int WORD_FLAGS_LSB = 8;
  localparam int WORD_MASK_LSB  = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h00;

  // ==========================================================
  // Datapath widths
  localparam int DATA_W  = 32;
  localparam int SHIFT_W = 5;

  typedef enum logic [1:0] {
    SIZE_BYTE = 2'b00,
    SIZE_WORD = 2'b01,
    SIZE_LONG = 2'b10
  } size_t;

  typedef enum logic [4:0] {
    OP_NOP              = 5'h00,
    OP_ADD              = 5'h01,
    OP_ADD_CARRY        = 5'h02,
    OP_SUB              = 5'h03,
    OP_SUB_BORROW       = 5'h04,
    OP_SHIFT_LEFT       = 5'h05,
    OP_SHIFT_RIGHT      = 5'h06,
    OP_SHIFT_RIGHT_ARI  = 5'h07,
    OP_NORMALIZE        = 5'h08,
    OP_CLEAR_TRAP       = 5'h09,
    OP_JUMP_IF_TRAP     = 5'h0A,
    OP_JUMP_IF_NO_TRAP  = 5'h0B,
    OP_ENABLE_TS        = 5'h0C,
    OP_DISABLE_TS       = 5'h0D,
    OP_ENABLE_INT       = 5'h0E,
    OP_DISABLE_INT      = 5'h0F,
    OP_PUSH_FLAGS       = 5'h10,
    OP_PUSH_ALL         = 5'h11,
    OP_POP_FLAGS        = 5'h12,
    OP_POP_ALL          = 5'h13
  } op_t;

endpackage : alu_status_word_flags_pkg

/* hdl/flag_eval.sv */
`timescale 1ns/100ps
module flag_eval
  import alu_status_word_flags_pkg::*;
(
  input  wire op_t                 i_op,
  input  wire size_t               i_size,
  input  wire logic [DATA_W-1:0]   i_src_a,
  input  wire logic [DATA_W-1:0]   i_src_b,
  input  wire logic                i_carry_in,
  input  wire logic [SHIFT_W-1:0]  i_shift_count,
  output logic      [DATA_W-1:0]   o_result,
  output logic                     o_zero,
  output logic                     o_negative,
  output logic                     o_overflow,
  output logic                     o_carry,
  output logic                     o_residue
);

  // ==========================================================
  // Width helpers
  function automatic logic [DATA_W-1:0] size_mask(input size_t size);
    unique case (size)
      SIZE_BYTE: size_mask = 32'h0000_00FF;
      SIZE_WORD: size_mask = 32'h0000_FFFF;
      SIZE_LONG: size_mask = 32'hFFFF_FFFF;
      default:   size_mask = 32'hFFFF_FFFF;
    endcase
  endfunction : size_mask

  function automatic logic msb_of(input logic [DATA_W-1:0] v, input size_t size);
    unique case (size)
      SIZE_BYTE: msb_of = v[7];
      SIZE_WORD: msb_of = v[15];
      default:   msb_of = v[31];
    endcase
  endfunction : msb_of

  // ==========================================================
  // Evaluation
  logic [DATA_W-1:0] m;
  logic [DATA_W-1:0] a;
  logic [DATA_W-1:0] b;
  logic [DATA_W:0]   wide;
  logic [DATA_W-1:0] sh;
  logic [DATA_W-1:0] top;
  logic              msb0;

  assign m = size_mask(i_size);
  assign a = i_src_a & m;
  assign b = i_src_b & m;

  always_comb begin
    wide       = '0;
    sh         = a;
    top        = m & ~(m >> 1);
    msb0       = msb_of(a, i_size);
    o_result   = '0;
    o_overflow = 1'b0;
    o_carry    = 1'b0;
    o_residue  = 1'b0;
    unique case (i_op)
      OP_ADD, OP_ADD_CARRY: begin
        wide = {1'b0, a} + {1'b0, b} + {32'h0, (i_op == OP_ADD_CARRY) & i_carry_in};
        o_result   = wide[DATA_W-1:0] & m;
        // Any bit above the field is the carry out
        o_carry    = wide[DATA_W] | (|(wide[DATA_W-1:0] & ~m)); // RULE8
        o_overflow = (msb_of(a, i_size) == msb_of(b, i_size)) &&
                     (msb_of(o_result, i_size) != msb_of(a, i_size)); // RULE5
      end
      OP_SUB, OP_SUB_BORROW: begin
        wide = {1'b0, a} - {1'b0, b} - {32'h0, (i_op == OP_SUB_BORROW) & ~i_carry_in};
        o_result   = wide[DATA_W-1:0] & m;
        // Carry is the inverse of borrow
        o_carry    = ~(wide[DATA_W] | (|(wide[DATA_W-1:0] & ~m))); // RULE9
        o_overflow = (msb_of(a, i_size) != msb_of(b, i_size)) &&
                     (msb_of(o_result, i_size) != msb_of(a, i_size)); // RULE5
      end
      OP_SHIFT_LEFT: begin
        for (int i = 0; i < DATA_W; i++) begin
          if (5'(i) < i_shift_count) begin
            o_carry = msb_of(sh, i_size); // RULE8
            sh      = (sh << 1) & m;
            if (msb_of(sh, i_size) != msb0) o_overflow = 1'b1; // RULE6
          end
        end
        o_result = sh;
      end
      OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_ARI: begin
        for (int i = 0; i < DATA_W; i++) begin
          if (5'(i) < i_shift_count) begin
            // A one already in carry is about to be lost
            if (o_carry) o_residue = 1'b1; // RULE10
            o_carry = sh[0]; // RULE8
            sh = (sh >> 1) |
                 (((i_op == OP_SHIFT_RIGHT_ARI) && msb_of(sh, i_size)) ? top : '0);
          end
        end
        o_result = sh;
      end
      OP_NORMALIZE: begin
        for (int i = 0; i < DATA_W; i++) begin
          if (!msb_of(sh, i_size) && (sh != '0)) sh = (sh << 1) & m;
        end
        o_result = sh;
      end
      default: o_result = '0;
    endcase
  end

  assign o_zero = (o_result == '0);
  // Shifts report the raw msb; add and subtract correct it by overflow
  assign o_negative = (i_op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_ARI,
                                    OP_NORMALIZE}) ? msb_of(o_result, i_size) :
                      (msb_of(o_result, i_size) ^ o_overflow); // RULE3 RULE4

endmodule : flag_eval

/* hdl/alu_status_word_flags.sv */
`timescale 1ns/100ps
module alu_status_word_flags
  import alu_status_word_flags_pkg::*;
(
  input  wire logic                i_ref_clk,
  input  wire logic                i_rst_n,
  input  wire logic                i_op_valid,
  input  wire op_t                 i_op,
  input  wire size_t               i_size,
  input  wire logic [DATA_W-1:0]   i_src_a,
  input  wire logic [DATA_W-1:0]   i_src_b,
  input  wire logic [SHIFT_W-1:0]  i_shift_count,
  input  wire logic [7:0]          i_int_mask,
  input  wire logic [7:0]          i_int_pending,
  input  wire logic [15:0]         i_pop_word,
  output logic      [DATA_W-1:0]   o_result,
  output logic                     o_result_valid,
  output logic      [7:0]          o_flags,
  output logic      [15:0]         o_push_word,
  output logic                     o_push_valid,
  output logic                     o_mask_clear,
  output logic                     o_mask_load,
  output logic      [7:0]          o_mask_data,
  output logic                     o_jump_valid,
  output logic                     o_jump_taken,
  output logic                     o_ts_enable,
  output logic                     o_int_enable,
  output logic      [7:0]          o_int_request
);

  // ==========================================================
  // Decoding
  function automatic logic is_arith(input op_t op);
    is_arith = (op inside {OP_ADD, OP_ADD_CARRY, OP_SUB, OP_SUB_BORROW,
                           OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_ARI,
                           OP_NORMALIZE});
  endfunction : is_arith

  function automatic logic is_chain(input op_t op);
    is_chain = (op == OP_ADD_CARRY) || (op == OP_SUB_BORROW);
  endfunction : is_chain

  function automatic logic is_push(input op_t op);
    is_push = (op == OP_PUSH_FLAGS) || (op == OP_PUSH_ALL);
  endfunction : is_push

  function automatic logic is_pop(input op_t op);
    is_pop = (op == OP_POP_FLAGS) || (op == OP_POP_ALL);
  endfunction : is_pop

  function automatic logic is_right(input op_t op);
    is_right = (op == OP_SHIFT_RIGHT) || (op == OP_SHIFT_RIGHT_ARI);
  endfunction : is_right

  // ==========================================================
  // Flag state
  logic              zero_reg;
  logic              negative_reg;
  logic              overflow_reg;
  logic              trap_reg;
  logic              carry_reg;
  logic              ts_enable_reg;
  logic              int_enable_reg;
  logic              residue_reg;
  logic [7:0]        flags;
  logic [DATA_W-1:0] ev_result;
  logic              ev_zero;
  logic              ev_negative;
  logic              ev_overflow;
  logic              ev_carry;
  logic              ev_residue;
  logic              do_arith;
  logic              do_push;
  logic              do_pop;

  assign flags = {zero_reg, negative_reg, overflow_reg, trap_reg,
                  carry_reg, ts_enable_reg, int_enable_reg, residue_reg};
  assign do_arith = i_op_valid && is_arith(i_op);
  assign do_push  = i_op_valid && is_push(i_op);
  assign do_pop   = i_op_valid && is_pop(i_op);

  flag_eval u_eval (
    .i_op          (i_op),
    .i_size        (i_size),
    .i_src_a       (i_src_a),
    .i_src_b       (i_src_b),
    .i_carry_in    (carry_reg),
    .i_shift_count (i_shift_count),
    .o_result      (ev_result),
    .o_zero        (ev_zero),
    .o_negative    (ev_negative),
    .o_overflow    (ev_overflow),
    .o_carry       (ev_carry),
    .o_residue     (ev_residue)
  );

  // ==========================================================
  // Condition flags
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      zero_reg     <= FLAGS_RESET[FLAG_ZERO]; // RULE16
      negative_reg <= FLAGS_RESET[FLAG_NEGATIVE];
      overflow_reg <= FLAGS_RESET[FLAG_OVERFLOW];
      carry_reg    <= FLAGS_RESET[FLAG_CARRY];
      residue_reg  <= FLAGS_RESET[FLAG_RESIDUE];
    end else if (do_push) begin
      zero_reg     <= 1'b0; // RULE13
      negative_reg <= 1'b0;
      overflow_reg <= 1'b0;
      carry_reg    <= 1'b0;
      residue_reg  <= 1'b0;
    end else if (do_pop) begin
      zero_reg     <= i_pop_word[WORD_FLAGS_LSB+FLAG_ZERO]; // RULE13
      negative_reg <= i_pop_word[WORD_FLAGS_LSB+FLAG_NEGATIVE];
      overflow_reg <= i_pop_word[WORD_FLAGS_LSB+FLAG_OVERFLOW];
      carry_reg    <= i_pop_word[WORD_FLAGS_LSB+FLAG_CARRY];
      residue_reg  <= i_pop_word[WORD_FLAGS_LSB+FLAG_RESIDUE];
    end else if (do_arith) begin
      // Carry chains may only clear zero so multi-word zero holds
      zero_reg     <= is_chain(i_op) ? (zero_reg & ev_zero) : ev_zero; // RULE1 RULE2
      negative_reg <= ev_negative; // RULE3 RULE4
      if (i_op != OP_NORMALIZE) begin
        overflow_reg <= ev_overflow; // RULE5 RULE6
        carry_reg    <= ev_carry; // RULE8 RULE9
      end
      if (is_right(i_op)) residue_reg <= ev_residue; // RULE10
    end
  end

  // ==========================================================
  // Latched trap
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      trap_reg <= FLAGS_RESET[FLAG_TRAP];
    end else if (do_push) begin
      trap_reg <= 1'b0;
    end else if (do_pop) begin
      trap_reg <= i_pop_word[WORD_FLAGS_LSB+FLAG_TRAP];
    end else if (do_arith && (i_op != OP_NORMALIZE) && ev_overflow) begin
      trap_reg <= 1'b1; // RULE7
    end else if (i_op_valid && (i_op inside {OP_CLEAR_TRAP, OP_JUMP_IF_TRAP,
                                             OP_JUMP_IF_NO_TRAP})) begin
      trap_reg <= 1'b0; // RULE7
    end
  end

  // ==========================================================
  // Global enables
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      ts_enable_reg  <= FLAGS_RESET[FLAG_TS_ENABLE];
      int_enable_reg <= FLAGS_RESET[FLAG_INT_EN];
    end else if (do_push) begin
      ts_enable_reg  <= 1'b0;
      int_enable_reg <= 1'b0;
    end else if (do_pop) begin
      ts_enable_reg  <= i_pop_word[WORD_FLAGS_LSB+FLAG_TS_ENABLE];
      int_enable_reg <= i_pop_word[WORD_FLAGS_LSB+FLAG_INT_EN];
    end else if (i_op_valid) begin
      if (i_op == OP_ENABLE_TS)   ts_enable_reg  <= 1'b1; // RULE11
      if (i_op == OP_DISABLE_TS)  ts_enable_reg  <= 1'b0; // RULE11
      if (i_op == OP_ENABLE_INT)  int_enable_reg <= 1'b1; // RULE12
      if (i_op == OP_DISABLE_INT) int_enable_reg <= 1'b0; // RULE12
    end
  end

  // ==========================================================
  // Outputs
  // The stack word carries the flags; o_flags also shows them directly
  always_ff @(posedge i_ref_clk) begin
    if (!i_rst_n) begin
      o_result       <= '0;
      o_result_valid <= 1'b0;
      o_push_word    <= '0;
      o_push_valid   <= 1'b0;
      o_mask_clear   <= 1'b0;
      o_mask_load    <= 1'b0;
      o_mask_data    <= '0;
      o_jump_valid   <= 1'b0;
      o_jump_taken   <= 1'b0;
      o_int_request  <= '0;
    end else begin
      o_result_valid <= do_arith;
      if (do_arith) o_result <= ev_result;
      o_push_valid   <= do_push;
      o_mask_clear   <= do_push; // RULE13
      if (do_push) o_push_word <= {flags, i_int_mask}; // RULE13 RULE14 RULE15
      o_mask_load    <= do_pop;
      if (do_pop) o_mask_data <= i_pop_word[WORD_MASK_LSB +: 8]; // RULE15
      o_jump_valid   <= i_op_valid && (i_op inside {OP_JUMP_IF_TRAP, OP_JUMP_IF_NO_TRAP});
      o_jump_taken   <= i_op_valid && ((i_op == OP_JUMP_IF_TRAP) ? trap_reg :
                        (i_op == OP_JUMP_IF_NO_TRAP) && !trap_reg);
      // Global enable gates every individual mask bit
      o_int_request  <= i_int_pending & i_int_mask & {8{int_enable_reg}}; // RULE12
    end
  end

  assign o_flags      = flags;
  assign o_ts_enable  = ts_enable_reg;
  assign o_int_enable = int_enable_reg;

  // ==========================================================
  // Checks
  logic [7:0] flags_q;
  logic       res_msb_q;

  always_ff @(posedge i_ref_clk) begin
    flags_q   <= flags;
    res_msb_q <= (i_size == SIZE_BYTE) ? ev_result[7] :
                 (i_size == SIZE_WORD) ? ev_result[15] : ev_result[31];
  end

  default clocking cb @(posedge i_ref_clk); endclocking
  default disable iff (!i_rst_n);

  property p_zero_set;
    do_arith && !is_chain(i_op) && (ev_result == '0) |=> zero_reg;
  endproperty
  a_zero_set: assert property (p_zero_set) else $error("zero flag not set"); // RULE1

  property p_chain_zero;
    do_arith && is_chain(i_op) && !zero_reg |=> !zero_reg;
  endproperty
  a_chain_zero: assert property (p_chain_zero) else $error("chain set zero"); // RULE2

  property p_true_sign;
    do_arith && (i_op inside {OP_ADD, OP_SUB}) |=>
      (negative_reg == (res_msb_q ^ overflow_reg));
  endproperty
  a_true_sign: assert property (p_true_sign) else $error("sign wrong"); // RULE3

  property p_shift_sign;
    do_arith && (i_op inside {OP_SHIFT_LEFT, OP_SHIFT_RIGHT, OP_SHIFT_RIGHT_ARI,
      OP_NORMALIZE}) |=> (negative_reg == res_msb_q);
  endproperty
  a_shift_sign: assert property (p_shift_sign) else $error("shift sign wrong"); // RULE4

  property p_add_overflow;
    do_arith && (i_op == OP_ADD) && (i_size == SIZE_BYTE) &&
      (i_src_a[7:0] == 8'h7F) && (i_src_b[7:0] == 8'h01) |=> overflow_reg && trap_reg;
  endproperty
  a_add_overflow: assert property (p_add_overflow) else $error("no overflow"); // RULE5

  property p_shl_overflow;
    do_arith && (i_op == OP_SHIFT_LEFT) && (i_size == SIZE_BYTE) &&
      (i_src_a[7:6] == 2'b01) && (i_shift_count == 5'h01) |=> overflow_reg;
  endproperty
  a_shl_overflow: assert property (p_shl_overflow) else $error("shl overflow"); // RULE6

  property p_trap_hold;
    trap_reg && !(i_op_valid && (i_op inside {OP_CLEAR_TRAP, OP_JUMP_IF_TRAP,
      OP_JUMP_IF_NO_TRAP, OP_POP_FLAGS, OP_POP_ALL, OP_PUSH_FLAGS, OP_PUSH_ALL}))
      |=> trap_reg;
  endproperty
  a_trap_hold: assert property (p_trap_hold) else $error("trap lost"); // RULE7

  property p_borrow;
    do_arith && (i_op == OP_SUB) && (i_size == SIZE_LONG) && (i_src_a < i_src_b)
      |=> !carry_reg;
  endproperty
  a_borrow: assert property (p_borrow) else $error("borrow kept carry"); // RULE9

  property p_residue;
    do_arith && is_right(i_op) && (i_shift_count == 5'h00) |=> !residue_reg && !carry_reg;
  endproperty
  a_residue: assert property (p_residue) else $error("residue on zero shift"); // RULE10

  property p_ts;
    i_op_valid && (i_op == OP_ENABLE_TS) |=> ts_enable_reg ##0 o_ts_enable;
  endproperty
  a_ts: assert property (p_ts) else $error("ts enable"); // RULE11

  property p_int_gate;
    (o_int_request != 8'h00) |-> $past(int_enable_reg);
  endproperty
  a_int_gate: assert property (p_int_gate) else $error("ungated request"); // RULE12

  property p_push;
    do_push |=> (flags == 8'h00) && o_push_valid && o_mask_clear &&
      (o_push_word[15:8] == flags_q);
  endproperty
  a_push: assert property (p_push) else $error("push wrong"); // RULE13

  property p_pop;
    do_pop ##1 1'b1 |-> (flags == $past(i_pop_word[15:8])) && o_mask_load;
  endproperty
  a_pop: assert property (p_pop) else $error("pop wrong"); // RULE15

  property p_norm_hold;
    do_arith && (i_op == OP_NORMALIZE) |=>
      (overflow_reg == $past(overflow_reg)) && (carry_reg == $past(carry_reg));
  endproperty
  a_norm_hold: assert property (p_norm_hold) else $error("normalize changed V or C"); // RULE16

  c_chain:    cover property (do_arith && is_chain(i_op) ##1 do_arith && is_chain(i_op));
  c_trap_jmp: cover property (trap_reg ##1 i_op_valid && (i_op == OP_JUMP_IF_TRAP));
  c_push_pop: cover property (do_push ##[1:4] do_pop);
  c_residue:  cover property (do_arith && is_right(i_op) ##1 residue_reg);
  c_shl_ovf:  cover property (do_arith && (i_op == OP_SHIFT_LEFT) ##1 overflow_reg);

endmodule : alu_status_word_flags

/* verif/alu_status_word_flags_bench.sv */
`timescale 1ns/100ps
module alu_status_word_flags_bench;
  import alu_status_word_flags_pkg::*;

  // ==========================================================
  // Stimulus and observation
  logic               ref_clk   = 1'b0;
  logic               rst_n     = 1'b0;
  logic               op_valid  = 1'b0;
  op_t                op        = OP_NOP;
  size_t              size      = SIZE_BYTE;
  logic [DATA_W-1:0]  src_a     = 32'h0000_0000;
  logic [DATA_W-1:0]  src_b     = 32'h0000_0000;
  logic [SHIFT_W-1:0] shift_cnt = 5'h00;
  logic [7:0]         int_mask  = 8'h0F;
  logic [7:0]         int_pend  = 8'h5A;
  logic [15:0]        pop_word  = 16'h0000;
  logic [DATA_W-1:0]  result;
  logic               result_valid;
  logic [7:0]         flags;
  logic [15:0]        push_word;
  logic               push_valid;
  logic               mask_clear;
  logic               mask_load;
  logic [7:0]         mask_data;
  logic               jump_valid;
  logic               jump_taken;
  logic               ts_enable;
  logic               int_enable;
  logic [7:0]         int_request;
  int                 n_fail    = 0;
  int                 checked   = 0;

  always #20 ref_clk = ~ref_clk;

  alu_status_word_flags i_dut (
    .i_ref_clk      (ref_clk),
    .i_rst_n        (rst_n),
    .i_op_valid     (op_valid),
    .i_op           (op),
    .i_size         (size),
    .i_src_a        (src_a),
    .i_src_b        (src_b),
    .i_shift_count  (shift_cnt),
    .i_int_mask     (int_mask),
    .i_int_pending  (int_pend),
    .i_pop_word     (pop_word),
    .o_result       (result),
    .o_result_valid (result_valid),
    .o_flags        (flags),
    .o_push_word    (push_word),
    .o_push_valid   (push_valid),
    .o_mask_clear   (mask_clear),
    .o_mask_load    (mask_load),
    .o_mask_data    (mask_data),
    .o_jump_valid   (jump_valid),
    .o_jump_taken   (jump_taken),
    .o_ts_enable    (ts_enable),
    .o_int_enable   (int_enable),
    .o_int_request  (int_request)
  );

  // ==========================================================
  // Comparisons and closing report
  task automatic cmp_byte(input string what, input logic [7:0] exp, input logic [7:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_byte

  task automatic cmp_wide(input string what, input logic [31:0] exp, input logic [31:0] got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", what, exp, got);
    end
  endtask : cmp_wide

  task automatic cmp_bit(input string what, input logic exp, input logic got);
    checked++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s expected %b seen %b", what, exp, got);
    end
  endtask : cmp_bit

  task automatic test_done;
    $display("comparisons %0d mismatches %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : test_done

  // ==========================================================
  // One instruction; answers are looked at in the cycle after it is taken
  task automatic step(input op_t o, input size_t sz, input logic [31:0] a,
                      input logic [31:0] b, input logic [4:0] cnt,
                      input logic [7:0] exp, input logic [7:0] msk);
    @(posedge ref_clk);
    op_valid  <= 1'b1;
    op        <= o;
    size      <= sz;
    src_a     <= a;
    src_b     <= b;
    shift_cnt <= cnt;
    @(posedge ref_clk);
    op_valid  <= 1'b0;
    #1;
    cmp_byte("flags", exp & msk, flags & msk);
  endtask : step

  task automatic check_reset_state;
    cmp_byte("flags", FLAGS_RESET, flags);
    cmp_bit("ts_enable", 1'b0, ts_enable);
    cmp_bit("int_enable", 1'b0, int_enable);
    cmp_byte("int_request", 8'h00, int_request);
  endtask : check_reset_state

  // ==========================================================
  // Scenarios
  task automatic run_add;
    step(OP_ADD, SIZE_BYTE, 32'h80, 32'h80, 5'h00, 8'hF8, 8'hFF);
    cmp_wide("result", 32'h0, result);
    cmp_bit("result_valid", 1'b1, result_valid);
    step(OP_ADD, SIZE_WORD, 32'h1, 32'h1, 5'h00, 8'h10, 8'hFF);
    cmp_wide("result", 32'h2, result);
    step(OP_ADD, SIZE_BYTE, 32'h7F, 32'h1, 5'h00, 8'h30, 8'hFF);
  endtask : run_add

  task automatic run_carry_chain;
    step(OP_ADD, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h90, 8'hFF);
    step(OP_ADD_CARRY, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h90, 8'hFF);
    step(OP_ADD_CARRY, SIZE_BYTE, 32'h1, 32'h0, 5'h00, 8'h10, 8'hFF);
    step(OP_ADD, SIZE_BYTE, 32'hFF, 32'h1, 5'h00, 8'h98, 8'hFF);
    step(OP_ADD_CARRY, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h10, 8'hFF);
    cmp_wide("result", 32'h1, result);
  endtask : run_carry_chain

  task automatic run_sub;
    step(OP_SUB, SIZE_LONG, 32'h1, 32'h2, 5'h00, 8'h50, 8'hFF);
    cmp_wide("result", 32'hFFFF_FFFF, result);
    step(OP_SUB, SIZE_WORD, 32'h2, 32'h1, 5'h00, 8'h18, 8'hFF);
    step(OP_SUB_BORROW, SIZE_WORD, 32'h5, 32'h5, 5'h00, 8'h18, 8'hFF);
    step(OP_SUB_BORROW, SIZE_WORD, 32'h5, 32'h6, 5'h00, 8'h50, 8'hFF);
    step(OP_SUB_BORROW, SIZE_WORD, 32'h5, 32'h5, 5'h00, 8'h50, 8'hFF);
    cmp_wide("result", 32'hFFFF, result);
  endtask : run_sub

  task automatic run_shift;
    step(OP_SHIFT_LEFT, SIZE_BYTE, 32'hC0, 32'h0, 5'h01, 8'h58, 8'hFF);
    cmp_wide("result", 32'h80, result);
    step(OP_SHIFT_LEFT, SIZE_BYTE, 32'h40, 32'h0, 5'h01, 8'h70, 8'hFF);
    step(OP_SHIFT_LEFT, SIZE_BYTE, 32'h80, 32'h0, 5'h00, 8'h50, 8'hFF);
    step(OP_SHIFT_RIGHT, SIZE_BYTE, 32'h3, 32'h0, 5'h02, 8'h99, 8'hFF);
    step(OP_SHIFT_RIGHT, SIZE_BYTE, 32'h81, 32'h0, 5'h00, 8'h50, 8'hFF);
    step(OP_SHIFT_RIGHT, SIZE_BYTE, 32'h2, 32'h0, 5'h02, 8'h98, 8'hFF);
    step(OP_SHIFT_RIGHT_ARI, SIZE_BYTE, 32'h80, 32'h0, 5'h01, 8'h50, 8'hFF);
    cmp_wide("result", 32'hC0, result);
    step(OP_NORMALIZE, SIZE_LONG, 32'h8000_0000, 32'h0, 5'h00, 8'h50, 8'hFF);
    step(OP_NORMALIZE, SIZE_LONG, 32'h0, 32'h0, 5'h00, 8'h90, 8'hFF);
  endtask : run_shift

  task automatic run_trap;
    step(OP_JUMP_IF_TRAP, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h80, 8'hFF);
    cmp_bit("jump_valid", 1'b1, jump_valid);
    cmp_bit("jump_taken", 1'b1, jump_taken);
    step(OP_JUMP_IF_NO_TRAP, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h80, 8'hFF);
    cmp_bit("jump_taken", 1'b1, jump_taken);
    step(OP_ADD, SIZE_BYTE, 32'h7F, 32'h1, 5'h00, 8'h30, 8'hFF);
    step(OP_JUMP_IF_NO_TRAP, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h20, 8'hFF);
    cmp_bit("jump_taken", 1'b0, jump_taken);
    step(OP_ADD, SIZE_BYTE, 32'h7F, 32'h1, 5'h00, 8'h30, 8'hFF);
    step(OP_CLEAR_TRAP, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h20, 8'hFF);
    step(op_t'(5'h14), SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h20, 8'hFF);
    cmp_bit("result_valid", 1'b0, result_valid);
    step(OP_NOP, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h20, 8'hFF);
  endtask : run_trap

  task automatic run_enables;
    step(OP_ENABLE_TS, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h24, 8'hFF);
    cmp_bit("ts_enable", 1'b1, ts_enable);
    step(OP_ENABLE_INT, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h26, 8'hFF);
    cmp_bit("int_enable", 1'b1, int_enable);
    @(posedge ref_clk);
    #1;
    cmp_byte("int_request", int_pend & int_mask, int_request);
    step(OP_DISABLE_INT, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h24, 8'hFF);
    @(posedge ref_clk);
    #1;
    cmp_byte("int_request", 8'h00, int_request);
    step(OP_DISABLE_TS, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h20, 8'hFF);
    cmp_bit("ts_enable", 1'b0, ts_enable);
    step(OP_ENABLE_TS, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h24, 8'hFF);
    step(OP_ENABLE_INT, SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h26, 8'hFF);
  endtask : run_enables

  task automatic run_push_pop;
    op_t         push_ops[2] = '{OP_PUSH_FLAGS, OP_PUSH_ALL};
    op_t         pop_ops[2]  = '{OP_POP_FLAGS, OP_POP_ALL};
    logic [15:0] words[2]    = '{16'hA5C3, 16'h5A3C};
    logic [7:0]  prev        = 8'h26;
    for (int i = 0; i < 2; i++) begin
      step(push_ops[i], SIZE_BYTE, 32'h0, 32'h0, 5'h00, 8'h00, 8'hFF);
      cmp_wide("push_word", {16'h0000, prev, int_mask}, {16'h0000, push_word});
      cmp_bit("push_valid", 1'b1, push_valid);
      cmp_bit("mask_clear", 1'b1, mask_clear);
      cmp_bit("ts_enable", 1'b0, ts_enable);
      @(posedge ref_clk);
      pop_word <= words[i];
      step(pop_ops[i], SIZE_BYTE, 32'h0, 32'h0, 5'h00, words[i][15:8], 8'hFF);
      cmp_byte("mask_data", words[i][7:0], mask_data);
      cmp_bit("mask_load", 1'b1, mask_load);
      prev = words[i][15:8];
    end
  endtask : run_push_pop

  task automatic run_mid_reset;
    @(posedge ref_clk);
    rst_n <= 1'b0;
    @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check_reset_state();
  endtask : run_mid_reset

  // ==========================================================
  // Main sequence and hang guard
  initial begin : watchdog
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    test_done();
  end

  initial begin : main
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'b1;
    #1;
    check_reset_state();
    run_add();
    run_carry_chain();
    run_sub();
    run_shift();
    run_trap();
    run_enables();
    run_push_pop();
    run_mid_reset();
    test_done();
  end

endmodule : alu_status_word_flags_bench
